// File: fscx_defs.vh
// Functional notes
// - Software clear works once count exceeds trigger
// - DMA writes above trigger clear low flag
// - Reset sets transmit low flag
// - Draining to trigger or below sets flag
// - Sixteen entries; low-flag write budget limited
// - Writes beyond permitted entries are discarded
// - Fill count in upper count byte
// - Serial clock idles high in synchronous mode
// - Receive-only clocks while enabled, FIFO at or below trigger
// - Receive-only internal clock gives 136 pulses
// - Overrun flag blocks transmit and receive
// - Low flag rising raises transmit interrupt
`ifndef FSCX_DEFS_VH
`define FSCX_DEFS_VH
`define FSCX_OFS_DATA    8'h00
`define FSCX_OFS_STATUS  8'h04
`define FSCX_OFS_CONTROL 8'h08
`define FSCX_OFS_COUNT   8'h0C
`define FSCX_OFS_LINE    8'h10
`define FSCX_OFS_TRIG    8'h14
`define FSCX_OFS_IRQ_ST  8'h18
`define FSCX_OFS_IRQ_MSK 8'h1C
`define FSCX_OFS_RXDATA  8'h20
`define FSCX_BIT_TX_END  0
`define FSCX_BIT_TX_LOW  5
`define FSCX_BIT_RX_RDY  1
`define FSCX_BIT_TE      5
`define FSCX_BIT_RE      4
`define FSCX_BIT_CKE     0
`define FSCX_BIT_OVERRUN_ERROR_FLAG    0
`define FSCX_IRQ_TXLOW   0
`define FSCX_IRQ_RXRDY   1
`define FSCX_IRQ_OVERRUN_ERROR_FLAG    2
`define FSCX_FIFO_DEPTH  16
`define FSCX_RX_PULSES   8'h88
`define FSCX_SCK_HALF    8
`define FSCX_TX_TRIG_RST 4'h8
`define FSCX_RX_TRIG_RST 5'h10
`endif

// File: fscx_fifo.v
`timescale 1ns/1ps
module fscx_fifo #(
    parameter W = 8,
    parameter D = 16,
    parameter AW = 4
) (
    input  wire          core_clk,
    input  wire          rst_n,
    input  wire          push,
    input  wire [W-1:0]  wdata,
    input  wire          pop,
    output wire [W-1:0]  rdata,
    output reg  [AW:0]   count
);
    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wp_reg;
    reg [AW-1:0] rp_reg;
    wire do_push = push && (count < D);
    wire do_pop  = pop && (count != {(AW+1){1'b0}});
    assign rdata = mem[rp_reg];
    always @(posedge core_clk) begin
        if (do_push)
            mem[wp_reg] <= wdata;
    end
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= {AW{1'b0}};
            rp_reg <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_push)
                wp_reg <= wp_reg + 1'b1;
            if (do_pop)
                rp_reg <= rp_reg + 1'b1;
            if (do_push && !do_pop)
                count <= count + 1'b1;
            else if (do_pop && !do_push)
                count <= count - 1'b1;
        end
    end
endmodule

// File: fscx_sync.v
`timescale 1ns/1ps
module fscx_sync (
    input  wire core_clk,
    input  wire rst_n,
    input  wire din,
    output reg  dout
);
    reg meta_reg;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b1;
            dout     <= 1'b1;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule

// File: fscx_channel.v
`timescale 1ns/1ps
`include "fscx_defs.vh"
module fscx_channel (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hsel,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        dma_wr,
    input  wire [7:0]  dma_wdata,
    input  wire        sck_in,
    output reg         sck_out,
    output reg         sck_oe_n,
    output reg         txd,
    input  wire        rxd,
    output reg         irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_LOW  = 3'b010;
    localparam ST_HIGH = 3'b100;

    reg        ap_valid_reg;
    reg        ap_write_reg;
    reg [7:0]  ap_addr_reg;
    reg [7:0]  ctrl_reg;
    reg [3:0]  tx_trig_reg;
    reg [4:0]  rx_trig_reg;
    reg        tx_low_reg;
    reg        tx_low_rd_reg;
    reg        tx_end_reg;
    reg        tx_end_rd_reg;
    reg        overrun_error_flag_reg;
    reg [2:0]  irq_st_reg;
    reg [2:0]  irq_msk_reg;
    reg [2:0]  state_reg;
    reg [3:0]  half_reg;
    reg [2:0]  bit_reg;
    reg [7:0]  tsh_reg;
    reg [7:0]  rsh_reg;
    reg        tx_act_reg;
    reg [7:0]  pulse_reg;
    reg        sck_d_reg;

    wire       rxd_s;
    wire       sck_s;
    wire [4:0] tx_cnt;
    wire [4:0] rx_cnt;
    wire [7:0] tx_q;
    wire [7:0] rx_q;

    wire te  = ctrl_reg[`FSCX_BIT_TE];
    wire re  = ctrl_reg[`FSCX_BIT_RE];
    wire ext = ctrl_reg[`FSCX_BIT_CKE];

    wire wr_hit = ap_valid_reg && ap_write_reg;
    wire rd_now = hsel && hready && htrans[1] && !hwrite;
    wire [7:0] ra = haddr[7:0];
    wire sw_data = wr_hit && ap_addr_reg == `FSCX_OFS_DATA;

    // Room left: while low, only depth minus trigger; else full depth
    wire [4:0] limit = tx_low_reg ? (5'd16 - {1'b0, tx_trig_reg})
                                  : 5'd16;
    wire push_req = (sw_data || dma_wr) && (tx_cnt < limit);
    wire [7:0] push_data = sw_data ? hwdata[7:0] : dma_wdata;

    wire tx_want = te && !overrun_error_flag_reg && tx_cnt != 5'd0;
    // Count checked at byte start, so the last of 17 bytes overruns
    wire rx_only = re && !te && !overrun_error_flag_reg && !ext
                   && rx_cnt <= rx_trig_reg
                   && pulse_reg != 8'd0;
    wire run = state_reg != ST_IDLE;
    wire sck_rise_int = state_reg == ST_LOW
                        && half_reg == `FSCX_SCK_HALF - 1;
    wire sck_rise = ext ? (sck_s && !sck_d_reg) : sck_rise_int;
    wire ext_busy = ext && (tx_act_reg || (re && !overrun_error_flag_reg));
    wire pop_tx = sck_rise && bit_reg == 3'd7 && tx_act_reg;
    wire byte_done = sck_rise && bit_reg == 3'd7;
    wire rx_push = byte_done && re && !overrun_error_flag_reg && rx_cnt < 5'd16;
    wire rx_ovr  = byte_done && re && !overrun_error_flag_reg && rx_cnt == 5'd16;
    wire rx_pop = rd_now && ra == `FSCX_OFS_RXDATA;
    wire [4:0] tx_cnt_next = tx_cnt + {4'd0, push_req}
                             - {4'd0, pop_tx && tx_cnt != 5'd0};

    fscx_fifo #(.W(8), .D(`FSCX_FIFO_DEPTH), .AW(4)) u_txf (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .push     (push_req),
        .wdata    (push_data),
        .pop      (pop_tx),
        .rdata    (tx_q),
        .count    (tx_cnt)
    );
    fscx_fifo #(.W(8), .D(`FSCX_FIFO_DEPTH), .AW(4)) u_rxf (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .push     (rx_push),
        .wdata    ({rsh_reg[6:0], rxd_s}),
        .pop      (rx_pop),
        .rdata    (rx_q),
        .count    (rx_cnt)
    );
    fscx_sync u_rxd (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      (rxd),
        .dout     (rxd_s)
    );
    fscx_sync u_sck (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      (sck_in),
        .dout     (sck_s)
    );

    // Bus slave: zero-wait, always OKAY
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg  <= 8'h00;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            hrdata       <= 32'h00000000;
        end else begin
            ap_valid_reg <= hsel && hready && htrans[1];
            ap_write_reg <= hwrite;
            ap_addr_reg  <= ra;
            if (rd_now) begin
                case (ra)
                `FSCX_OFS_STATUS:  hrdata <= {26'd0, tx_low_reg, 3'd0,
                                    rx_cnt != 5'd0, tx_end_reg};
                `FSCX_OFS_CONTROL: hrdata <= {24'd0, ctrl_reg};
                `FSCX_OFS_COUNT:   hrdata <= {19'd0, tx_cnt,
                                    3'd0, rx_cnt};
                `FSCX_OFS_LINE:    hrdata <= {31'd0, overrun_error_flag_reg};
                `FSCX_OFS_TRIG:    hrdata <= {19'd0, rx_trig_reg,
                                    4'd0, tx_trig_reg};
                `FSCX_OFS_IRQ_ST:  hrdata <= {29'd0, irq_st_reg};
                `FSCX_OFS_IRQ_MSK: hrdata <= {29'd0, irq_msk_reg};
                `FSCX_OFS_RXDATA:  hrdata <= {24'd0, rx_q};
                default:           hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Registers, flags and interrupts
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg      <= 8'h00;
            tx_trig_reg   <= `FSCX_TX_TRIG_RST;
            rx_trig_reg   <= `FSCX_RX_TRIG_RST;
            tx_low_reg    <= 1'b1;
            tx_low_rd_reg <= 1'b0;
            tx_end_reg    <= 1'b1;
            tx_end_rd_reg <= 1'b0;
            overrun_error_flag_reg      <= 1'b0;
            irq_st_reg    <= 3'b000;
            irq_msk_reg   <= 3'b000;
            irq           <= 1'b0;
        end else begin
            if (wr_hit && ap_addr_reg == `FSCX_OFS_CONTROL)
                ctrl_reg <= hwdata[7:0];
            if (wr_hit && ap_addr_reg == `FSCX_OFS_TRIG) begin
                tx_trig_reg <= hwdata[3:0];
                rx_trig_reg <= hwdata[12:8];
            end
            if (wr_hit && ap_addr_reg == `FSCX_OFS_IRQ_MSK)
                irq_msk_reg <= hwdata[2:0];
            if (rd_now && ra == `FSCX_OFS_STATUS) begin
                tx_low_rd_reg <= tx_low_reg;
                tx_end_rd_reg <= tx_end_reg;
            end
            // Low flag: set on drain wins over any clear
            if (pop_tx && tx_cnt_next <= {1'b0, tx_trig_reg})
                tx_low_reg <= 1'b1;
            else if (tx_low_reg && tx_cnt_next > {1'b0, tx_trig_reg}
                     && (dma_wr || tx_low_rd_reg
                     && wr_hit && ap_addr_reg == `FSCX_OFS_STATUS
                     && !hwdata[`FSCX_BIT_TX_LOW]))
                tx_low_reg <= 1'b0;
            if (wr_hit && ap_addr_reg == `FSCX_OFS_STATUS)
                tx_low_rd_reg <= 1'b0;
            if (pop_tx && tx_cnt == 5'd1)
                tx_end_reg <= 1'b1;
            else if (wr_hit && ap_addr_reg == `FSCX_OFS_STATUS
                     && tx_end_rd_reg && !hwdata[`FSCX_BIT_TX_END])
                tx_end_reg <= 1'b0;
            if (rx_ovr)
                overrun_error_flag_reg <= 1'b1;
            else if (wr_hit && ap_addr_reg == `FSCX_OFS_LINE
                     && !hwdata[`FSCX_BIT_OVERRUN_ERROR_FLAG])
                overrun_error_flag_reg <= 1'b0;
            irq_st_reg <= (irq_st_reg & ~((wr_hit
                          && ap_addr_reg == `FSCX_OFS_IRQ_ST)
                          ? hwdata[2:0] : 3'b000))
                          | {rx_ovr, rx_push,
                             pop_tx && !tx_low_reg
                             && tx_cnt_next <= {1'b0, tx_trig_reg}};
            irq <= |(irq_st_reg & irq_msk_reg);
        end
    end

    // Serial engine: clock idles high between bytes
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= ST_IDLE;
            half_reg   <= 4'd0;
            bit_reg    <= 3'd0;
            tsh_reg    <= 8'hFF;
            rsh_reg    <= 8'h00;
            tx_act_reg <= 1'b0;
            pulse_reg  <= `FSCX_RX_PULSES;
            sck_out    <= 1'b1;
            sck_oe_n   <= 1'b1;
            txd        <= 1'b1;
            sck_d_reg  <= 1'b1;
        end else begin
            sck_d_reg <= sck_s;
            sck_oe_n  <= ext;
            if (!re || te)
                pulse_reg <= `FSCX_RX_PULSES;
            case (state_reg)
            ST_IDLE: begin
                sck_out <= 1'b1;
                if (!tx_act_reg && (tx_want || (!ext && rx_only))) begin
                    tx_act_reg <= tx_want;
                    tsh_reg    <= tx_want ? tx_q : 8'hFF;
                    txd        <= tx_want ? tx_q[0] : 1'b1;
                    bit_reg    <= 3'd0;
                    half_reg   <= 4'd0;
                    if (!ext) begin
                        state_reg <= ST_LOW;
                        sck_out   <= 1'b0;
                    end
                end else if (ext && (tx_act_reg || ext_busy) && sck_rise) begin
                    rsh_reg <= {rsh_reg[6:0], rxd_s};
                    bit_reg <= bit_reg + 3'd1;
                    tsh_reg <= {1'b1, tsh_reg[7:1]};
                    txd     <= tsh_reg[1];
                    if (bit_reg == 3'd7)
                        tx_act_reg <= 1'b0;
                end
            end
            ST_LOW: begin
                half_reg <= half_reg + 4'd1;
                if (sck_rise_int) begin
                    half_reg <= 4'd0;
                    sck_out  <= 1'b1;
                    state_reg <= ST_HIGH;
                    rsh_reg  <= {rsh_reg[6:0], rxd_s};
                    if (re && !te && pulse_reg != 8'd0)
                        pulse_reg <= pulse_reg - 8'd1;
                end
            end
            ST_HIGH: begin
                half_reg <= half_reg + 4'd1;
                if (half_reg == `FSCX_SCK_HALF - 1) begin
                    half_reg <= 4'd0;
                    bit_reg  <= bit_reg + 3'd1;
                    if (bit_reg == 3'd7) begin
                        tx_act_reg <= 1'b0;
                        state_reg  <= ST_IDLE;
                    end else begin
                        tsh_reg   <= {1'b1, tsh_reg[7:1]};
                        txd       <= tsh_reg[1];
                        sck_out   <= 1'b0;
                        state_reg <= ST_LOW;
                    end
                end
            end
            default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

// File: fscx_chk.sv
`timescale 1ns/1ps
module fscx_chk (
    input wire        core_clk,
    input wire        rst_n,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hsel,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        sck_out,
    input wire        sck_oe_n,
    input wire        txd,
    input wire        irq
);
    reg       ctl_wr_q;
    reg [5:0] ctl_q;
    reg [8:0] rx_pulse_cnt;
    reg [9:0] idle_cnt;
    wire      rx_only = ctl_q[4] && !ctl_q[5] && !ctl_q[0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Shadow of the control register, taken from bus writes
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_wr_q <= 1'b0;
            ctl_q <= 6'h00;
            rx_pulse_cnt <= 9'h000;
            idle_cnt <= 10'h000;
        end else begin
            ctl_wr_q <= hsel && hready && htrans[1] && hwrite
                        && haddr[7:0] == 8'h08;
            if (ctl_wr_q)
                ctl_q <= hwdata[5:0];
            if (!rx_only)
                rx_pulse_cnt <= 9'h000;
            else if ($fell(sck_out))
                rx_pulse_cnt <= rx_pulse_cnt + 9'h001;
            if (ctl_q[5] || ctl_q[4])
                idle_cnt <= 10'h000;
            else if (idle_cnt != 10'h3FF)
                idle_cnt <= idle_cnt + 10'h001;
        end
    end
    chk_ready_always: assert property (hreadyout)
        else $error("hreadyout dropped");
    chk_resp_okay: assert property (!hresp)
        else $error("error response seen");
    chk_reset_idle: assert property (
        $rose(rst_n) |-> sck_out && sck_oe_n && txd && !irq)
        else $error("outputs not idle after reset");
    chk_sck_low_half: assert property (
        $fell(sck_out) |-> (!sck_out) [*8] ##1 sck_out)
        else $error("serial clock low phase wrong");
    chk_sck_high_half: assert property (
        $rose(sck_out) |-> sck_out [*8])
        else $error("serial clock high phase short");
    chk_ext_no_drive: assert property (
        ctl_q[0] && $past(ctl_q[0], 3) |-> sck_oe_n && sck_out)
        else $error("clock driven in external mode");
    chk_rx_pulse_cap: assert property (
        rx_pulse_cnt <= 9'h088)
        else $error("too many receive-only pulses");
    chk_idle_high: assert property (
        idle_cnt >= 10'h12C |-> sck_out)
        else $error("serial clock not high when idle");
    cover property (rx_pulse_cnt == 9'h088);
    cover property ($rose(irq));
    cover property ($fell(sck_out) && !sck_oe_n);
endmodule
bind fscx_channel fscx_chk fscx_chk_inst (
    .core_clk(core_clk), .rst_n(rst_n), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsel(hsel), .hready(hready),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .txd(txd), .irq(irq));

// File: fscx_peer.sv
`timescale 1ns/1ps
module fscx_peer (
    input  wire       sck_out,
    input  wire       sck_oe_n,
    input  wire       txd,
    output reg        sck_in,
    output reg        rxd,
    output reg  [7:0] tx_byte,
    output int        pulses
);
    initial begin
        sck_in = 1'b1;
        rxd = 1'b1;
        tx_byte = 8'h00;
        pulses = 0;
    end
    // New receive bit on every falling edge the device drives
    always @(negedge sck_out) begin
        if (!sck_oe_n) begin
            pulses++;
            rxd = ~rxd;
        end
    end
    // External clock frame, 64 ns period, high between frames
    task ext_frame(input int n);
        repeat (n) begin
            #32 sck_in = 1'b0;
            rxd = ~rxd;
            #32 sck_in = 1'b1;
            tx_byte = {txd, tx_byte[7:1]};
        end
    endtask
endmodule

// File: fscx_tb.sv
`timescale 1ns/1ps
`include "fscx_defs.vh"
`define CHK(n, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("wrong value %s expected %h seen %h", n, e, g); \
    end \
end
module testbench;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hsel = 1'b1;
    logic        dma_wr = 1'b0;
    logic [7:0]  dma_wdata = 8'h00;
    logic [31:0] hrdata;
    logic [31:0] rv;
    logic        hreadyout, hresp, sck_out, sck_oe_n, txd, irq;
    logic        sck_in, rxd;
    logic [7:0]  tx_byte;
    int          pulses;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cyc = 0;
    fscx_channel fscx_channel_inst (
        .core_clk(core_clk), .rst_n(rst_n), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .dma_wr(dma_wr), .dma_wdata(dma_wdata), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .txd(txd),
        .rxd(rxd), .irq(irq));
    fscx_peer fscx_peer_inst (
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .txd(txd),
        .sck_in(sck_in), .rxd(rxd), .tx_byte(tx_byte),
        .pulses(pulses));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic print_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic bus(input bit w, input [7:0] a, input [31:0] d);
        @(posedge core_clk);
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rv = hrdata;
    endtask
    task automatic poll(input [7:0] a, input [31:0] m, input [31:0] v);
        for (int i = 0; i < 1000; i++) begin
            bus(1'b0, a, 32'h0);
            if ((rv & m) === v)
                break;
        end
    endtask
    // Software clear of the low and end flags: read, write zero, read
    task automatic sw_clear();
        bus(1'b0, `FSCX_OFS_STATUS, 32'h0);
        bus(1'b1, `FSCX_OFS_STATUS, 32'h0);
        bus(1'b0, `FSCX_OFS_STATUS, 32'h0);
    endtask
    task automatic test_reset();
        bus(1'b0, `FSCX_OFS_STATUS, 32'h0);
        `CHK("status", 32'h21, rv & 32'h23)
        bus(1'b0, `FSCX_OFS_COUNT, 32'h0);
        `CHK("tx count", 5'h00, rv[12:8])
    endtask
    task automatic test_low_limit();
        for (int i = 0; i < 12; i++) bus(1'b1, `FSCX_OFS_DATA, i);
        bus(1'b0, `FSCX_OFS_COUNT, 32'h0);
        `CHK("count at low limit", 5'h08, rv[12:8])
        sw_clear();
        `CHK("low flag kept", 1'b1, rv[5])
        bus(1'b1, `FSCX_OFS_TRIG, 32'h1002);
        sw_clear();
        `CHK("low flag cleared", 1'b0, rv[5])
        for (int i = 0; i < 10; i++) bus(1'b1, `FSCX_OFS_DATA, 32'h40 + i);
        bus(1'b0, `FSCX_OFS_COUNT, 32'h0);
        `CHK("count at depth", 5'h10, rv[12:8])
    endtask
    task automatic test_drain();
        bus(1'b1, `FSCX_OFS_IRQ_MSK, 32'h1);
        bus(1'b1, `FSCX_OFS_CONTROL, 32'h20);
        poll(`FSCX_OFS_STATUS, 32'h20, 32'h20);
        `CHK("low flag set", 1'b1, rv[5])
        `CHK("irq", 1'b1, irq)
        bus(1'b0, `FSCX_OFS_IRQ_ST, 32'h0);
        `CHK("irq status", 1'b1, rv[0])
        bus(1'b1, `FSCX_OFS_IRQ_ST, 32'h1);
        bus(1'b0, `FSCX_OFS_COUNT, 32'h0);
        `CHK("count at trigger", 1'b1, rv[12:8] <= 5'h02)
        `CHK("irq cleared", 1'b0, irq)
        poll(`FSCX_OFS_STATUS, 32'h1, 32'h1);
        bus(1'b1, `FSCX_OFS_CONTROL, 32'h0);
    endtask
    task automatic test_rx_only();
        int p0;
        p0 = pulses;
        bus(1'b1, `FSCX_OFS_CONTROL, 32'h10);
        repeat (2600) @(posedge core_clk);
        `CHK("rx pulses", 136, pulses - p0)
        bus(1'b0, `FSCX_OFS_COUNT, 32'h0);
        `CHK("rx count", 5'h10, rv[4:0])
        bus(1'b0, `FSCX_OFS_LINE, 32'h0);
        `CHK("overrun", 1'b1, rv[0])
    endtask
    task automatic test_overrun();
        bus(1'b1, `FSCX_OFS_CONTROL, 32'h21);
        bus(1'b1, `FSCX_OFS_DATA, 32'h5A);
        fscx_peer_inst.ext_frame(8);
        bus(1'b0, `FSCX_OFS_COUNT, 32'h0);
        `CHK("tx held", 5'h01, rv[12:8])
        bus(1'b1, `FSCX_OFS_LINE, 32'h0);
        fscx_peer_inst.ext_frame(8);
        repeat (4) @(posedge core_clk);
        bus(1'b0, `FSCX_OFS_COUNT, 32'h0);
        `CHK("tx resumed", 5'h00, rv[12:8])
        `CHK("tx byte", 8'h5A, tx_byte)
        bus(1'b1, `FSCX_OFS_CONTROL, 32'h0);
    endtask
    task automatic test_dma();
        bus(1'b0, 8'h40, 32'h0);
        `CHK("okay resp", 1'b0, hresp)
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            dma_wr <= 1'b1;
            dma_wdata <= 8'hA1 + i[7:0];
        end
        @(posedge core_clk);
        dma_wr <= 1'b0;
        bus(1'b0, `FSCX_OFS_STATUS, 32'h0);
        `CHK("low flag after dma", 1'b0, rv[5])
        bus(1'b0, `FSCX_OFS_COUNT, 32'h0);
        `CHK("dma count", 5'h03, rv[12:8])
    endtask
    // Exact receive count with the internal clock: send n dummies
    task automatic test_rx_exact();
        int p0;
        for (int i = 0; i < 16; i++) bus(1'b0, `FSCX_OFS_RXDATA, 32'h0);
        p0 = pulses;
        bus(1'b1, `FSCX_OFS_CONTROL, 32'h30);
        poll(`FSCX_OFS_COUNT, 32'h1F00, 32'h0);
        repeat (20) @(posedge core_clk);
        bus(1'b0, `FSCX_OFS_COUNT, 32'h0);
        `CHK("rx count exact", 5'h03, rv[4:0])
        `CHK("exact pulses", 24, pulses - p0)
        bus(1'b1, `FSCX_OFS_CONTROL, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        test_reset();
        test_low_limit();
        test_drain();
        test_rx_only();
        test_overrun();
        test_dma();
        test_rx_exact();
        print_verdict();
    end
endmodule
